// ===== hdl/pmfz_core.sv
// Flag, averaging, window and zero-crossing back end of a power monitor.
// Assumes samples, RMS results and the fast current arrive synchronous to clk_i;
// the RMS arithmetic itself sits outside and is paced by window_end_o.
//
// Summary of operation
// - Delay voltage or current channel by the programmed amount, at most five degrees.
// - Two averaging paths; source fields route vrms, irms or active power.
// - Each path has two cascaded stages; all stage outputs readable.
// - Overvoltage when vrms above upper, undervoltage when below lower threshold.
// - Voltage flags set only after the programmed count of consecutive sets.
// - Fast current compared against a trip level clamped to 0.65..2.0 of range.
// - Optional trip delay of up to 32 us before reporting overcurrent.
// - Window sized by voltage zero crossings unless bypass is set.
// - With bypass, window is the fixed sample count of 32 kHz samples.
// - Fixed counts below four are replaced by four.
// - In fixed mode first valid RMS comes after twice the count.
// - Two-wire mode turns two pins into flag outputs.
// - Flag pins are active low; host reads low as asserted.
// - Flag 0 selects zero crossing, overvoltage, undervoltage or the OR of the two voltage flags.
// - Flag 1 selects overcurrent, undervoltage, overvoltage or OR with latched trip.
// - Window uses voltage crossings even when current crossings are reported.
// - Voltage crossings reported as short pulses or as a square wave.
// - Edge select 0 picks falling, 1 rising crossings, both channels.
// - Every-edge field pulses on both crossing directions.
// - Pulse width is 32 us for select 0, 256 us for select 1.
// - Square wave toggles each crossing; edge select aligns the rising transition.
// - Channel select reports current crossings, pulse mode only, same options.
// - Overcurrent uses the separate 12-bit 1 MHz current value.
// - Without bypass, each rising voltage crossing closes the window; count grows per sample.
`include "pmfz_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pmfz_core
  import pmfz_pkg::*;
#(
  parameter int DEL_DEPTH = 8,
  parameter int ZC_WIDE_CYC = `PMFZ_ZC_WIDE_US * `PMFZ_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Nonvolatile configuration image
  input wire logic [95:0] nv_cfg_i,
  // 32 kHz samples
  input wire logic sample_stb_i,
  input wire pmfz_sample_t sample_i,
  output pmfz_sample_t sample_del_o,
  // RMS results and window pacing
  input wire logic rms_stb_i,
  input wire pmfz_rms_t rms_i,
  output logic window_end_o,
  output logic [10:0] window_n_o,
  // Fast current, 1 MHz
  input wire logic oc_stb_i,
  input wire logic signed [11:0] oc_current_i,
  // Flag pins
  output logic flag0_n_o,
  output logic flag0_oe_o,
  output logic flag1_n_o,
  output logic flag1_oe_o
);
  localparam int ZC_NARROW_CYC = `PMFZ_ZC_NARROW_US * `PMFZ_CLK_MHZ;
  localparam int OC_DLY_MAX_CYC = `PMFZ_OC_DLY_MAX_US * `PMFZ_CLK_MHZ;

  pmfz_cfg_t cfg_reg;
  pmfz_state_t state_reg;
  logic run;
  logic wb_req;
  logic [31:0] wmask;

  function automatic logic [15:0] avg_src(input logic [1:0] s, input pmfz_rms_t r);
    unique case (s)
      2'h0: avg_src = r.vrms;
      2'h1: avg_src = r.irms;
      default: avg_src = r.pact;
    endcase
  endfunction

  assign run = (state_reg == PMFZ_RUN);
  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Configuration: loaded from the image, then writable by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PMFZ_LOAD;
      cfg_reg <= '0;
    end else if (!run) begin
      cfg_reg <= pmfz_cfg_t'(nv_cfg_i);
      state_reg <= PMFZ_RUN;
    end else if (wb_req && we_i) begin
      unique case (adr_i)
        `PMFZ_CFG0_OFF: cfg_reg[31:0] <= (cfg_reg[31:0] & ~wmask) | (dat_i & wmask);
        `PMFZ_CFG1_OFF: cfg_reg[63:32] <= (cfg_reg[63:32] & ~wmask) | (dat_i & wmask);
        `PMFZ_CFG2_OFF: cfg_reg[95:64] <= (cfg_reg[95:64] & ~wmask) | (dat_i & wmask);
        default: ;
      endcase
    end
  end

  // Channel phase delay
  pmfz_sample_t hist [DEL_DEPTH];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < DEL_DEPTH; k++) hist[k] <= '0;
      sample_del_o <= '0;
    end else if (sample_stb_i && run) begin
      hist[0] <= sample_i;
      for (int k = 1; k < DEL_DEPTH; k++) hist[k] <= hist[k-1];
      sample_del_o <= sample_i;
      if (cfg_reg.del_amt != 3'h0) begin
        if (cfg_reg.del_cur) sample_del_o.i <= hist[cfg_reg.del_amt - 3'h1].i;
        else sample_del_o.v <= hist[cfg_reg.del_amt - 3'h1].v;
      end
    end
  end

  // Zero-crossing detection with a sample holdoff; 0 voltage, 1 current
  logic [1:0] pos_reg;
  logic [1:0] primed_reg;
  logic [3:0] hold_reg [2];
  logic [1:0] rise_x;
  logic [1:0] fall_x;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rise_x[c] = 1'b0;
      fall_x[c] = 1'b0;
    end
    if (sample_stb_i && run) begin
      rise_x[0] = primed_reg[0] && !pos_reg[0] && !sample_i.v[15] && hold_reg[0] == 4'h0;
      fall_x[0] = primed_reg[0] && pos_reg[0] && sample_i.v[15] && hold_reg[0] == 4'h0;
      rise_x[1] = primed_reg[1] && !pos_reg[1] && !sample_i.i[15] && hold_reg[1] == 4'h0;
      fall_x[1] = primed_reg[1] && pos_reg[1] && sample_i.i[15] && hold_reg[1] == 4'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= 2'b00;
      primed_reg <= 2'b00;
      hold_reg[0] <= 4'h0;
      hold_reg[1] <= 4'h0;
    end else if (sample_stb_i && run) begin
      for (int c = 0; c < 2; c++) begin
        if (!primed_reg[c]) begin
          // First sample after reset only learns the sign, so no false crossing
          pos_reg[c] <= (c == 0) ? !sample_i.v[15] : !sample_i.i[15];
          primed_reg[c] <= 1'b1;
        end else if (rise_x[c] || fall_x[c]) begin
          pos_reg[c] <= rise_x[c];
          hold_reg[c] <= `PMFZ_ZC_HOLD;
        end else if (hold_reg[c] != 4'h0) begin
          hold_reg[c] <= hold_reg[c] - 4'h1;
        end
      end
    end
  end

  // Zero-crossing output: pulse or square wave
  logic zc_ch;
  logic zc_hit;
  logic zc_reg;
  logic sq_reg;
  logic [12:0] zc_cnt_reg;
  assign zc_ch = cfg_reg.zc_chan;
  assign zc_hit = cfg_reg.every_edge ? (rise_x[zc_ch] | fall_x[zc_ch])
                : (cfg_reg.edge_sel ? rise_x[zc_ch] : fall_x[zc_ch]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sq_reg <= 1'b0;
    end else if (rise_x[0]) begin
      sq_reg <= cfg_reg.edge_sel;
    end else if (fall_x[0]) begin
      sq_reg <= !cfg_reg.edge_sel;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zc_cnt_reg <= '0;
    end else if (zc_hit) begin
      zc_cnt_reg <= cfg_reg.width_sel ? 13'(ZC_WIDE_CYC) : 13'(ZC_NARROW_CYC);
    end else if (zc_cnt_reg != '0) begin
      zc_cnt_reg <= zc_cnt_reg - 13'h1;
    end
  end
  always_comb begin
    if (cfg_reg.sq_en && !cfg_reg.zc_chan) zc_reg = sq_reg;
    else zc_reg = (zc_cnt_reg != '0);
  end

  // Calculation window
  logic [10:0] n_cnt_reg;
  logic [10:0] n_eff;
  logic [1:0] win_seen_reg;
  logic win_close;
  assign n_eff = (cfg_reg.n_fixed < `PMFZ_N_MIN) ? `PMFZ_N_MIN : cfg_reg.n_fixed;
  always_comb begin
    if (cfg_reg.bypass_n) win_close = sample_stb_i && run && (n_cnt_reg + 11'h1 >= n_eff);
    else win_close = rise_x[0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_cnt_reg <= '0;
      window_end_o <= 1'b0;
      window_n_o <= '0;
      win_seen_reg <= 2'h0;
    end else begin
      window_end_o <= win_close;
      if (win_close) begin
        window_n_o <= cfg_reg.bypass_n ? n_eff : n_cnt_reg;
        n_cnt_reg <= cfg_reg.bypass_n ? 11'h0 : 11'h1;
        if (win_seen_reg != 2'h2) win_seen_reg <= win_seen_reg + 2'h1;
      end else if (sample_stb_i && run && n_cnt_reg != 11'h7ff) begin
        n_cnt_reg <= n_cnt_reg + 11'h1;
      end
    end
  end

  // RMS results count only once the fixed window has run twice
  logic rms_ok;
  assign rms_ok = rms_stb_i && run && (!cfg_reg.bypass_n || win_seen_reg == 2'h2);

  // Over and undervoltage with consecutive event count
  logic ov_reg;
  logic uv_reg;
  logic [3:0] ov_cnt_reg;
  logic [3:0] uv_cnt_reg;
  logic [3:0] ev_need;
  assign ev_need = (cfg_reg.vevent_cycs == 4'h0) ? 4'h1 : cfg_reg.vevent_cycs;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_reg <= 1'b0;
      uv_reg <= 1'b0;
      ov_cnt_reg <= 4'h0;
      uv_cnt_reg <= 4'h0;
    end else if (rms_ok) begin
      if (rms_i.vrms > cfg_reg.ov_th) begin
        if (ov_cnt_reg + 4'h1 >= ev_need) ov_reg <= 1'b1;
        if (ov_cnt_reg != 4'hf) ov_cnt_reg <= ov_cnt_reg + 4'h1;
      end else begin
        ov_reg <= 1'b0;
        ov_cnt_reg <= 4'h0;
      end
      if (rms_i.vrms < cfg_reg.uv_th) begin
        if (uv_cnt_reg + 4'h1 >= ev_need) uv_reg <= 1'b1;
        if (uv_cnt_reg != 4'hf) uv_cnt_reg <= uv_cnt_reg + 4'h1;
      end else begin
        uv_reg <= 1'b0;
        uv_cnt_reg <= 4'h0;
      end
    end
  end

  // Averaging: two paths, two cascaded power-of-two stages each
  logic [22:0] acc_reg [2][2];
  logic [6:0] cnt_reg [2][2];
  logic [15:0] avg_reg [2][2];
  logic [15:0] st_in [2][2];
  logic [1:0] st_go [2];
  logic [1:0] st_done [2];
  logic [2:0] st_log [2];
  logic [22:0] st_sum [2][2];
  always_comb begin
    st_log[0] = cfg_reg.avg1_log;
    st_log[1] = cfg_reg.avg2_log;
    for (int p = 0; p < 2; p++) begin
      st_in[p][0] = avg_src(p == 0 ? cfg_reg.path0_src : cfg_reg.path1_src, rms_i);
      st_go[p][0] = rms_ok;
      st_in[p][1] = 16'((acc_reg[p][0] + 23'(st_in[p][0])) >> st_log[0]);
      for (int s = 0; s < 2; s++) begin
        st_sum[p][s] = acc_reg[p][s] + 23'(st_in[p][s]);
        st_done[p][s] = st_go[p][s] && (cnt_reg[p][s] == 7'((8'h1 << st_log[s]) - 8'h1));
      end
      st_go[p][1] = st_done[p][0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < 2; s++) begin
          acc_reg[p][s] <= '0;
          cnt_reg[p][s] <= '0;
          avg_reg[p][s] <= '0;
        end
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < 2; s++) begin
          if (st_done[p][s]) begin
            avg_reg[p][s] <= 16'(st_sum[p][s] >> st_log[s]);
            acc_reg[p][s] <= '0;
            cnt_reg[p][s] <= '0;
          end else if (st_go[p][s]) begin
            acc_reg[p][s] <= st_sum[p][s];
            cnt_reg[p][s] <= cnt_reg[p][s] + 7'h1;
          end
        end
      end
    end
  end

  // Overcurrent trip on the fast path
  logic [10:0] oc_mag;
  logic [10:0] oc_lvl;
  logic oc_over_reg;
  logic oc_reg;
  logic oc_lat_reg;
  logic [9:0] oc_dly_reg;
  logic [9:0] oc_need;
  logic oc_clr;
  // Full negative scale has no 11-bit magnitude; saturate so it still trips
  assign oc_mag = (oc_current_i == 12'sh800) ? 11'h7ff
                : oc_current_i[11] ? 11'(-oc_current_i) : oc_current_i[10:0];
  assign oc_lvl = (cfg_reg.oc_level < `PMFZ_OC_MIN) ? `PMFZ_OC_MIN
                : (cfg_reg.oc_level > `PMFZ_OC_MAX) ? `PMFZ_OC_MAX : cfg_reg.oc_level;
  assign oc_need = (cfg_reg.flt_dly_us > 6'(`PMFZ_OC_DLY_MAX_US)) ? 10'(OC_DLY_MAX_CYC)
                 : 10'(cfg_reg.flt_dly_us * `PMFZ_CLK_MHZ);
  assign oc_clr = wb_req && we_i && adr_i == `PMFZ_STAT_OFF && sel_i[0]
                  && dat_i[`PMFZ_ST_OCLAT];
  always_ff @(posedge clk_i) begin
    if (rst_i) oc_over_reg <= 1'b0;
    else if (oc_stb_i && run) oc_over_reg <= (oc_mag > oc_lvl);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_dly_reg <= '0;
      oc_reg <= 1'b0;
    end else if (!oc_over_reg) begin
      oc_dly_reg <= '0;
      oc_reg <= 1'b0;
    end else if (oc_dly_reg >= oc_need) begin
      oc_reg <= 1'b1;
    end else begin
      oc_dly_reg <= oc_dly_reg + 10'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) oc_lat_reg <= 1'b0;
    else if (oc_reg) oc_lat_reg <= 1'b1;
    else if (oc_clr) oc_lat_reg <= 1'b0;
  end

  // Flag pin routing, driven low when asserted
  logic f0;
  logic f1;
  always_comb begin
    unique case (cfg_reg.dio0_sel)
      2'h0: f0 = zc_reg;
      2'h1: f0 = ov_reg;
      2'h2: f0 = uv_reg;
      default: f0 = ov_reg | uv_reg;
    endcase
    unique case (cfg_reg.dio1_sel)
      2'h0: f1 = oc_reg;
      2'h1: f1 = uv_reg;
      2'h2: f1 = ov_reg;
      default: f1 = ov_reg | uv_reg | oc_lat_reg;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag0_n_o <= 1'b1;
      flag1_n_o <= 1'b1;
      flag0_oe_o <= 1'b0;
      flag1_oe_o <= 1'b0;
    end else begin
      flag0_n_o <= ~f0;
      flag1_n_o <= ~f1;
      flag0_oe_o <= run && cfg_reg.two_wire;
      flag1_oe_o <= run && cfg_reg.two_wire;
    end
  end

  // Bus answer
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    unique case (adr_i)
      `PMFZ_CFG0_OFF: rd = cfg_reg[31:0];
      `PMFZ_CFG1_OFF: rd = cfg_reg[63:32];
      `PMFZ_CFG2_OFF: rd = cfg_reg[95:64];
      `PMFZ_STAT_OFF: rd = {26'h0, run, zc_reg, oc_lat_reg, oc_reg, uv_reg, ov_reg};
      `PMFZ_AVG_OFF: rd = {avg_reg[0][1], avg_reg[0][0]};
      `PMFZ_AVG1_OFF: rd = {avg_reg[1][1], avg_reg[1][0]};
      default: rd = '0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) dat_o <= rd;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pmfz_params.svh
// Constants of the power monitor flag and zero-crossing block.
// Assumes a 25 MHz core clock and a 32-bit classic Wishbone register bus.
`ifndef PMFZ_PARAMS_SVH
`define PMFZ_PARAMS_SVH
// Register byte offsets
`define PMFZ_CFG0_OFF 8'h00
`define PMFZ_CFG1_OFF 8'h04
`define PMFZ_CFG2_OFF 8'h08
`define PMFZ_STAT_OFF 8'h0c
`define PMFZ_AVG_OFF 8'h10
`define PMFZ_AVG1_OFF 8'h14
// Status bit positions
`define PMFZ_ST_OV 0
`define PMFZ_ST_UV 1
`define PMFZ_ST_OC 2
`define PMFZ_ST_OCLAT 3
`define PMFZ_ST_ZC 4
`define PMFZ_ST_RUN 5
// Clock and times
`define PMFZ_CLK_MHZ 25
`define PMFZ_ZC_NARROW_US 32
`define PMFZ_ZC_WIDE_US 256
`define PMFZ_OC_DLY_MAX_US 32
// Window, trip and zero-crossing holdoff limits
`define PMFZ_N_MIN 11'h004
`define PMFZ_OC_MIN 11'h14d
`define PMFZ_OC_MAX 11'h400
`define PMFZ_ZC_HOLD 4'h8
`endif

// ===== hdl/pmfz_pkg.sv
// Types of the power monitor flag and zero-crossing block.
// Assumes pmfz_params.svh for numeric constants.
package pmfz_pkg;
  // Word 2 is the top, word 0 the bottom of the vector
  typedef struct packed {
    logic [3:0] vevent_cycs;
    logic [5:0] flt_dly_us;
    logic [10:0] oc_level;
    logic [10:0] n_fixed;
    logic [15:0] uv_th;
    logic [15:0] ov_th;
    logic [6:0] rsv;
    logic zc_chan;
    logic width_sel;
    logic every_edge;
    logic edge_sel;
    logic sq_en;
    logic [1:0] dio1_sel;
    logic [1:0] dio0_sel;
    logic two_wire;
    logic bypass_n;
    logic [2:0] avg2_log;
    logic [2:0] avg1_log;
    logic [1:0] path1_src;
    logic [1:0] path0_src;
    logic [2:0] del_amt;
    logic del_cur;
  } pmfz_cfg_t;

  typedef struct packed {
    logic signed [15:0] v;
    logic signed [15:0] i;
  } pmfz_sample_t;

  typedef struct packed {
    logic [15:0] vrms;
    logic [15:0] irms;
    logic [15:0] pact;
  } pmfz_rms_t;

  typedef enum logic [0:0] {PMFZ_LOAD, PMFZ_RUN} pmfz_state_t;
endpackage

// ===== test/pmfz_core_props.sv
// Checker of the flag pins, window pacing and sample delay of pmfz_core.
// Assumes nv_cfg_i only changes while reset is high and CFG0 and CFG2 are never rewritten.
`timescale 1ns/1ns
`default_nettype none
module pmfz_core_props
  import pmfz_pkg::*;
#(
  parameter int DEL_DEPTH = 8,
  parameter int ZC_WIDE_CYC = 6400
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Inputs
  input wire logic sample_stb_i,
  input wire logic [95:0] nv_cfg_i,
  // Outputs
  input wire pmfz_sample_t sample_del_o,
  input wire logic window_end_o,
  input wire logic [10:0] window_n_o,
  input wire logic flag0_n_o,
  input wire logic flag0_oe_o,
  input wire logic flag1_n_o,
  input wire logic flag1_oe_o
);
  pmfz_cfg_t cfg;
  logic [10:0] n_eff;
  logic zc_pulse;
  logic [12:0] low_cnt;
  assign cfg = pmfz_cfg_t'(nv_cfg_i);
  assign n_eff = (cfg.n_fixed < 11'h004) ? 11'h004 : cfg.n_fixed;
  assign zc_pulse = cfg.two_wire && cfg.dio0_sel == 2'h0 && !cfg.sq_en;
  // Length of the present low stretch on flag 0
  always_ff @(posedge clk_i) begin
    if (rst_i || flag0_n_o) begin
      low_cnt <= 13'h0000;
    end else begin
      low_cnt <= low_cnt + 13'h0001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_oe_mode: assert property (flag0_oe_o |-> cfg.two_wire && flag1_oe_o)
    else $error("pin enable outside two-wire mode");
  chk_oe_run: assert property ((cfg.two_wire && !rst_i) [*4] |-> flag0_oe_o)
    else $error("pin enable missing in run");
  chk_rst_idle: assert property ($fell(rst_i) |-> flag0_n_o && flag1_n_o && !window_end_o)
    else $error("flag pins not idle after reset");
  chk_zc_width: assert property ($rose(flag0_n_o) && zc_pulse |->
    low_cnt == (cfg.width_sel ? 13'(ZC_WIDE_CYC) : 13'h320))
    else $error("zero crossing pulse width wrong");
  chk_win_stb: assert property (window_end_o |-> $past(sample_stb_i))
    else $error("window end without sample");
  chk_win_fixed: assert property (window_end_o && cfg.bypass_n |-> window_n_o == n_eff)
    else $error("fixed window length wrong");
  chk_del_hold: assert property (!sample_stb_i |=> $stable(sample_del_o))
    else $error("delayed sample moved without strobe");
  chk_same_ov: assert property (cfg.two_wire && cfg.dio0_sel == 2'h1 && cfg.dio1_sel == 2'h2
    |-> flag0_n_o == flag1_n_o)
    else $error("overvoltage differs on the two pins");
  chk_or_flags: assert property (cfg.two_wire && cfg.dio0_sel == 2'h3 && cfg.dio1_sel == 2'h3
    && !flag0_n_o |-> !flag1_n_o)
    else $error("flag 1 misses a voltage flag");
endmodule
bind pmfz_core pmfz_core_props #(.DEL_DEPTH(DEL_DEPTH), .ZC_WIDE_CYC(ZC_WIDE_CYC))
  u_pmfz_core_props (.clk_i(clk_i), .rst_i(rst_i), .sample_stb_i(sample_stb_i),
  .nv_cfg_i(nv_cfg_i), .sample_del_o(sample_del_o), .window_end_o(window_end_o),
  .window_n_o(window_n_o), .flag0_n_o(flag0_n_o), .flag0_oe_o(flag0_oe_o),
  .flag1_n_o(flag1_n_o), .flag1_oe_o(flag1_oe_o));
`default_nettype wire

// ===== test/pmfz_host.sv
// Host model that watches the two flag pins.
// Assumes pull-ups on both pins, so a released pin reads high.
`timescale 1ns/1ns
`default_nettype none
module pmfz_host (
  // Clock and count clear
  input wire logic clk_i,
  input wire logic clr_i,
  // Flag pins
  input wire logic flag0_n_i,
  input wire logic flag0_oe_i,
  input wire logic flag1_n_i,
  input wire logic flag1_oe_i,
  // Decoded view
  output logic flag0_on_o,
  output logic flag1_on_o,
  output logic [7:0] events0_o
);
  logic pin0;
  logic pin1;
  logic prev0;
  assign pin0 = flag0_oe_i ? flag0_n_i : 1'b1;
  assign pin1 = flag1_oe_i ? flag1_n_i : 1'b1;
  assign flag0_on_o = !pin0;
  assign flag1_on_o = !pin1;
  // Count assertions of flag 0
  always @(posedge clk_i) begin
    prev0 <= pin0;
    if (clr_i) begin
      events0_o <= 8'h00;
    end else if (prev0 === 1'b1 && pin0 === 1'b0) begin
      events0_o <= events0_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_pmfz_core.sv
// Self-checking bench of pmfz_core with a host model on the flag pins.
// Assumes requests are made no earlier than two edges after reset release.
`timescale 1ns/1ns
`default_nettype none
module tb_pmfz_core;
  import pmfz_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sample_stb_i, rms_stb_i, window_end_o;
  logic oc_stb_i, flag0_n_o, flag0_oe_o, flag1_n_o, flag1_oe_o, flag0_on, flag1_on, clr;
  logic [7:0] adr_i, ev0;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rnd;
  logic [95:0] nv_cfg_i;
  logic signed [11:0] oc_current_i;
  logic signed [15:0] iv, s;
  logic [10:0] window_n_o;
  pmfz_sample_t sample_i, sample_del_o;
  pmfz_rms_t rms_i;
  pmfz_cfg_t cfg, c;
  logic [31:0] exp_q[$];
  logic [4:0] zm [5] = '{5'h00, 5'h05, 5'h02, 5'h08, 5'h10};
  int ze [5] = '{3, 2, 5, 3, 3};
  int err_count, samples_checked, win_count;
  assign nv_cfg_i = cfg;
  pmfz_core #(.DEL_DEPTH(8), .ZC_WIDE_CYC(64)) u_pmfz_core (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .nv_cfg_i(nv_cfg_i), .sample_stb_i(sample_stb_i),
    .sample_i(sample_i), .sample_del_o(sample_del_o), .rms_stb_i(rms_stb_i), .rms_i(rms_i),
    .window_end_o(window_end_o), .window_n_o(window_n_o), .oc_stb_i(oc_stb_i),
    .oc_current_i(oc_current_i), .flag0_n_o(flag0_n_o), .flag0_oe_o(flag0_oe_o),
    .flag1_n_o(flag1_n_o), .flag1_oe_o(flag1_oe_o));
  pmfz_host u_pmfz_host (.clk_i(clk_i), .clr_i(clr), .flag0_n_i(flag0_n_o),
    .flag0_oe_i(flag0_oe_o), .flag1_n_i(flag1_n_o), .flag1_oe_i(flag1_oe_o),
    .flag0_on_o(flag0_on), .flag1_on_o(flag1_on), .events0_o(ev0));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] sl);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= sl;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // Read data is compared at the acknowledging edge
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) check("read data", dat_o, exp_q.pop_front());
    if (window_end_o === 1'b1) win_count++;
  end
  task automatic restart(input pmfz_cfg_t nc);
    cfg <= nc;
    rst_i <= 1'b1;
    clr <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    clr <= 1'b0;
    win_count = 0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic smp(input logic signed [15:0] v, input logic signed [15:0] i, input int gap);
    sample_stb_i <= 1'b1;
    sample_i <= {v, i};
    @(posedge clk_i);
    sample_stb_i <= 1'b0;
    repeat (gap - 1) @(posedge clk_i);
  endtask
  task automatic ocp(input logic signed [11:0] cur, input int n);
    repeat (n) begin
      oc_stb_i <= 1'b1;
      oc_current_i <= cur;
      @(posedge clk_i);
      oc_stb_i <= 1'b0;
      repeat (24) @(posedge clk_i);
    end
  endtask
  task automatic rmsp(input logic [15:0] vr, input int n);
    repeat (n) begin
      rms_stb_i <= 1'b1;
      rms_i <= {vr, 32'h0};
      @(posedge clk_i);
      rms_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    #(40 * 80000);
    err_count++;
    final_report();
  end
  initial begin
    {rst_i, clr, cyc_i, stb_i, we_i, sample_stb_i, rms_stb_i, oc_stb_i} = 8'hff;
    {cyc_i, stb_i, we_i, sample_stb_i, rms_stb_i, oc_stb_i} = 6'h00;
    {adr_i, sel_i, dat_i, sample_i, rms_i, oc_current_i, cfg} = '0;
    rnd = 32'h26de;
    err_count = 0;
    samples_checked = 0;
    for (int k = 0; k < 3; k++) begin
      c = '0;
      {c.two_wire, c.bypass_n, c.n_fixed, c.vevent_cycs, c.flt_dly_us} = {2'h3, 11'h002,
        4'h3, 6'h01};
      {c.ov_th, c.uv_th, c.dio0_sel, c.dio1_sel} = {16'h8000, 16'h1000,
        (k == 2) ? 4'h8 : (k == 1) ? 4'hf : 4'h6};
      {c.avg1_log, c.avg2_log, c.path1_src, c.del_amt, c.del_cur} = {3'h1, 3'h1, 2'h1, 3'h2,
        k[0]};
      restart(c);
      rd(8'h0c, 32'h20);
      for (int a = 0; a < 3; a++) rd(8'(4 * a), c[32 * a +: 32]);
      rnd = xs(rnd);
      bus(1'b1, 8'h04, rnd, 4'h0);
      bus(1'b1, 8'h20, rnd, 4'hf);
      rd(8'h20, 32'h0);
      rd(8'h04, c[63:32]);
      ocp(12'sh14c, 3);
      rd(8'h0c, 32'h20);
      oc_stb_i <= 1'b1;
      oc_current_i <= 12'sh14e;
      @(posedge clk_i);
      oc_stb_i <= 1'b0;
      rd(8'h0c, 32'h20);
      ocp(12'sh14e, 2);
      rd(8'h0c, 32'h2c);
      check("flag1", flag1_on, k != 0);
      ocp(12'sh000, 2);
      rd(8'h0c, 32'h28);
      check("flag1", flag1_on, k == 1);
      bus(1'b1, 8'h0c, 32'h8, 4'hf);
      rd(8'h0c, 32'h20);
      rmsp(16'h9000, 3);
      rd(8'h0c, 32'h20);
      for (int j = 1; j < 9; j++) smp(16'(j), 16'(j), 4);
      check("windows", win_count, 2);
      check("window n", window_n_o, 4);
      check("delayed", sample_del_o, k[0] ? 32'h00080006 : 32'h00060008);
      rmsp(16'h9000, 2);
      rd(8'h0c, 32'h20);
      rmsp(16'h9000, 1);
      rd(8'h0c, 32'h21);
      check("flag0", flag0_on, k != 2);
      check("flag1", flag1_on, k != 2);
      rmsp(16'h0800, 3);
      rd(8'h0c, 32'h22);
      check("flag0", flag0_on, k != 0);
      check("flag1", flag1_on, k == 1);
      rd(8'h10, 32'h6e000800);
      rd(8'h14, 32'h0);
      $display("test flags %0d done", k);
    end
    for (int m = 0; m < 5; m++) begin
      c = '0;
      c.two_wire = 1'b1;
      {c.sq_en, c.zc_chan, c.width_sel, c.every_edge, c.edge_sel} = zm[m];
      restart(c);
      for (int h = 0; h < 7; h++) begin
        for (int j = 0; j < 10; j++) begin
          rnd = xs(rnd);
          iv = {8'h01, rnd[7:0]};
          s = h[0] ? -iv : iv;
          smp((h == 0) ? iv : -s, s, 100);
        end
      end
      check("zc events", ev0, ze[m]);
      check("windows", win_count, 2);
      check("window n", window_n_o, 20);
      $display("test zc %0d done", m);
    end
    final_report();
  end
endmodule
`default_nettype wire
